/* src/tcm_defs.vh */
// register map, field positions, reset values and timing for tcm_chan_cfg
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH
// register byte offsets
`define TCM_OFS_MODE 8'h00
`define TCM_OFS_CHEN 8'h04
`define TCM_OFS_TRIG 8'h08
`define TCM_OFS_CLKS 8'h0C
`define TCM_OFS_CMP1 8'h10
`define TCM_OFS_CMP2 8'h14
`define TCM_OFS_STAT 8'h18
// printed locations of the channel 3/4 mode registers (not held here)
`define TCM_ADDR_T1_CH34 32'h4000_E01C
`define TCM_ADDR_T2_CH34 32'h4000_F01C
// reset values
`define TCM_RST_MODE 16'h0000
`define TCM_RST_CMP 16'h0000
// channel 1 field positions; channel 2 sits TCM_CH_STRIDE bits higher
`define TCM_CH_STRIDE 8
`define TCM_F_DIR 0
`define TCM_F_FAST 2
`define TCM_F_BUF 3
`define TCM_F_OCM 4
`define TCM_F_PSC 2
`define TCM_F_FILT 4
// direction codes
`define TCM_DIR_OUT 2'b00
`define TCM_DIR_OWN 2'b01
`define TCM_DIR_OTHER 2'b10
`define TCM_DIR_TRIG 2'b11
// output compare pwm modes
`define TCM_OCM_PWM1 3'b110
`define TCM_OCM_PWM2 3'b111
// clock rates and derived sampling tick divisors
`define TCM_PCLK_HZ 125000000
`define TCM_XTAL_PCLK_HZ 12000000
`define TCM_RC_PCLK_HZ 6000000
`define TCM_DIV_XTAL (`TCM_PCLK_HZ / `TCM_XTAL_PCLK_HZ)
`define TCM_DIV_RC (`TCM_PCLK_HZ / `TCM_RC_PCLK_HZ)
// trigger to output delay in clock cycles
`define TCM_FAST_DLY 3
`define TCM_SLOW_DLY 5
`endif

/* src/tcm_chan_cfg.v */
// channel 1/2 capture/compare mode configuration with apb register slave
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_defs.vh"

module tcm_chan_cfg (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire timer_input_one,
    input wire timer_input_two,
    input wire [7:0] internal_trigger,
    input wire update_event,
    output reg [1:0] cap_event_q,
    output reg [1:0] oc_trig_match_q,
    output reg [2:0] chan1_output_mode,
    output reg [2:0] chan2_output_mode,
    output reg [1:0] fast_enable_q,
    output reg [15:0] cmp1_active_q,
    output reg [15:0] cmp2_active_q
);

    // filter table entry: {sample rate shift[2:0], sample count n[3:0]}
    function [6:0] filt_cfg;
        input [3:0] code;
        begin
            case (code)
                4'h1: filt_cfg = {3'd0, 4'd2};
                4'h2: filt_cfg = {3'd0, 4'd4};
                4'h3: filt_cfg = {3'd0, 4'd8};
                4'h4: filt_cfg = {3'd1, 4'd6};
                4'h5: filt_cfg = {3'd1, 4'd8};
                4'h6: filt_cfg = {3'd2, 4'd6};
                4'h7: filt_cfg = {3'd2, 4'd8};
                4'h8: filt_cfg = {3'd3, 4'd6};
                4'h9: filt_cfg = {3'd3, 4'd8};
                4'hA: filt_cfg = {3'd4, 4'd5};
                4'hB: filt_cfg = {3'd4, 4'd6};
                4'hC: filt_cfg = {3'd4, 4'd8};
                4'hD: filt_cfg = {3'd5, 4'd5};
                4'hE: filt_cfg = {3'd5, 4'd6};
                4'hF: filt_cfg = {3'd5, 4'd8};
                default: filt_cfg = {3'd0, 4'd1};
            endcase
        end
    endfunction

    // events per capture, minus one, for a prescale code
    function [2:0] psc_last;
        input [1:0] code;
        begin
            case (code)
                2'b01: psc_last = 3'd1;
                2'b10: psc_last = 3'd3;
                2'b11: psc_last = 3'd5;
                default: psc_last = 3'd0;
            endcase
        end
    endfunction

    reg [15:0] mode_q;
    reg [1:0] chan_on_q;
    reg [2:0] trig_sel_q;
    reg clk_rc_q;
    reg [15:0] cmp1_buf_q;
    reg [15:0] cmp2_buf_q;
    reg [31:0] rd_d;
    reg hit_d;
    reg [1:0] filt_q;
    wire [1:0] in_mode;
    wire [1:0] buf_on;
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pwrite & pready;

    // read mux and address decode; unmapped offsets answer with an error
    always @* begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        case (paddr)
            `TCM_OFS_MODE: rd_d = {16'h0000, mode_q};
            `TCM_OFS_CHEN: rd_d = {30'h0000_0000, chan_on_q};
            `TCM_OFS_TRIG: rd_d = {29'h0000_0000, trig_sel_q};
            `TCM_OFS_CLKS: rd_d = {31'h0000_0000, clk_rc_q};
            `TCM_OFS_CMP1: rd_d = {16'h0000, cmp1_buf_q};
            `TCM_OFS_CMP2: rd_d = {16'h0000, cmp2_buf_q};
            `TCM_OFS_STAT: rd_d = {28'h0000_000, in_mode, filt_q};
            default: hit_d = 1'b0;
        endcase
    end

    // bus answer is prepared in the setup cycle so access needs no wait
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= ~hit_d;
            end
        end
    end

    // register writes take effect at the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= `TCM_RST_MODE;
            chan_on_q <= 2'b00;
            trig_sel_q <= 3'b000;
            clk_rc_q <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                // direction bits simply stored, software keeps ch off
                `TCM_OFS_MODE: mode_q <= pwdata[15:0];
                `TCM_OFS_CHEN: chan_on_q <= pwdata[1:0];
                `TCM_OFS_TRIG: trig_sel_q <= pwdata[2:0];
                `TCM_OFS_CLKS: clk_rc_q <= pwdata[0];
                default: ;
            endcase
        end
    end

    // compare buffers, loaded into active at update event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp1_buf_q <= `TCM_RST_CMP;
            cmp2_buf_q <= `TCM_RST_CMP;
            cmp1_active_q <= `TCM_RST_CMP;
            cmp2_active_q <= `TCM_RST_CMP;
        end else begin
            if (wr_en && paddr == `TCM_OFS_CMP1)
                cmp1_buf_q <= pwdata[15:0];
            if (wr_en && paddr == `TCM_OFS_CMP2)
                cmp2_buf_q <= pwdata[15:0];
            // unbuffered: the written value goes live at once
            if (wr_en && paddr == `TCM_OFS_CMP1 && !buf_on[0])
                cmp1_active_q <= pwdata[15:0];
            else if (update_event && buf_on[0])
                cmp1_active_q <= cmp1_buf_q;
            if (wr_en && paddr == `TCM_OFS_CMP2 && !buf_on[1])
                cmp2_active_q <= pwdata[15:0];
            else if (update_event && buf_on[1])
                cmp2_active_q <= cmp2_buf_q;
        end
    end

    // two-stage synchronisers for the pins and trigger sources
    reg [9:0] meta_q;
    reg [9:0] sync_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 10'h000;
            sync_q <= 10'h000;
        end else begin
            meta_q <= {internal_trigger, timer_input_two, timer_input_one};
            sync_q <= meta_q;
        end
    end

    // trigger source picked by the trigger select field
    wire trig_lvl = sync_q[2 + trig_sel_q];
    reg trig_prev_q;
    reg [3:0] trig_dly_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_q <= 1'b0;
            trig_dly_q <= 4'h0;
        end else begin
            trig_prev_q <= trig_lvl;
            trig_dly_q <= {trig_dly_q[2:0], trig_lvl & ~trig_prev_q};
        end
    end

    // peripheral sampling tick, every 10 or 20 pclk cycles (12.5 MHz or 6.25 MHz)
    reg [4:0] tick_cnt_q;
    reg [4:0] rate_cnt_q;
    wire [4:0] tick_last = clk_rc_q ? 5'd19 : 5'd9;
    wire tick = (tick_cnt_q == tick_last);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 5'd0;
            rate_cnt_q <= 5'd0;
        end else begin
            tick_cnt_q <= tick ? 5'd0 : tick_cnt_q + 5'd1;
            if (tick)
                rate_cnt_q <= rate_cnt_q + 5'd1;
        end
    end

    // per-channel logic; channel 2 fields sit one stride above channel 1
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            localparam integer B = i * `TCM_CH_STRIDE;
            wire [1:0] dir = mode_q[B + `TCM_F_DIR +: 2];
            wire [3:0] fcode = mode_q[B + `TCM_F_FILT +: 4];
            wire [1:0] pcode = mode_q[B + `TCM_F_PSC +: 2];
            wire [2:0] ocm = mode_q[B + `TCM_F_OCM +: 3];
            wire [6:0] fc = filt_cfg(fcode);
            wire [4:0] rmask = (5'd1 << fc[6:4]) - 5'd1;
            wire samp = tick & ((rate_cnt_q & rmask) == 5'd0);
            reg src;
            reg [3:0] agree_q;
            reg [2:0] ev_q;
            reg filt_prev_q;
            // ch2 01 own pin (ti2), 10 other pin (ti1)
            // ch1 01 own pin (ti1), 10 other pin (ti2)
            always @* begin
                case (dir)
                    `TCM_DIR_OWN: src = sync_q[i];
                    `TCM_DIR_OTHER: src = sync_q[1 - i];
                    `TCM_DIR_TRIG: src = trig_lvl;
                    default: src = 1'b0;
                endcase
            end
            assign in_mode[i] = (dir != `TCM_DIR_OUT);
            // buffer enable only honoured for an output
            assign buf_on[i] = ~in_mode[i] & mode_q[B + `TCM_F_BUF];
            // filter decode shared by both channels
            // new level passes after n agreeing samples
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt_q[i] <= 1'b0;
                    agree_q <= 4'd0;
                end else if (fcode == 4'h0) begin
                    filt_q[i] <= src;
                    agree_q <= 4'd0;
                end else if (src == filt_q[i]) begin
                    agree_q <= 4'd0;
                end else if (samp) begin
                    if (agree_q + 4'd1 >= fc[3:0]) begin
                        filt_q[i] <= src;
                        agree_q <= 4'd0;
                    end else begin
                        agree_q <= agree_q + 4'd1;
                    end
                end
            end
            // ch2 prescale counts rising edges, input only
            // ch1 uses the same event count encoding
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt_prev_q <= 1'b0;
                    ev_q <= 3'd0;
                    cap_event_q[i] <= 1'b0;
                end else begin
                    filt_prev_q <= filt_q[i];
                    cap_event_q[i] <= 1'b0;
                    if (!in_mode[i]) begin
                        ev_q <= 3'd0;
                    end else if (filt_q[i] & ~filt_prev_q) begin
                        if (ev_q >= psc_last(pcode)) begin
                            ev_q <= 3'd0;
                            cap_event_q[i] <= 1'b1;
                        end else begin
                            ev_q <= ev_q + 3'd1;
                        end
                    end
                end
            end
            // fast enable honoured only for an output
            // pwm trigger edge acts as match, 3 or 5 cycles
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fast_enable_q[i] <= 1'b0;
                    oc_trig_match_q[i] <= 1'b0;
                end else begin
                    fast_enable_q[i] <= ~in_mode[i] &
                        mode_q[B + `TCM_F_FAST];
                    oc_trig_match_q[i] <= ~in_mode[i] &
                        (ocm == `TCM_OCM_PWM1 || ocm == `TCM_OCM_PWM2) &
                        (mode_q[B + `TCM_F_FAST] ?
                         trig_dly_q[`TCM_FAST_DLY - 2] :
                         trig_dly_q[`TCM_SLOW_DLY - 2]);
                end
            end
        end
    endgenerate

    // output modes forced to frozen while a channel is an input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan1_output_mode <= 3'b000;
            chan2_output_mode <= 3'b000;
        end else begin
            chan1_output_mode <= in_mode[0] ? 3'b000 :
                mode_q[`TCM_F_OCM +: 3];
            chan2_output_mode <= in_mode[1] ? 3'b000 :
                mode_q[`TCM_CH_STRIDE + `TCM_F_OCM +: 3];
        end
    end

endmodule // tcm_chan_cfg
`default_nettype wire

/* src/tcm_placeholder_note.v */
// empty compilation unit kept for folder layout
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* dv/tcm_chan_cfg_sva.sv */
// port-level checker for tcm_chan_cfg
`timescale 1ns/100ps
`default_nettype none
`include "tcm_defs.vh"
module tcm_chan_cfg_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic update_event,
    input wire logic [1:0] cap_event_q,
    input wire logic [1:0] oc_trig_match_q,
    input wire logic [2:0] chan1_output_mode,
    input wire logic [2:0] chan2_output_mode,
    input wire logic [1:0] fast_enable_q,
    input wire logic [15:0] cmp1_active_q
);
    logic [15:0] mode_q;
    logic [15:0] buf_q;
    wire wr = psel & penable & pwrite & pready;
    // shadow of what software wrote, so outputs can be tied to it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 16'h0000;
            buf_q <= 16'h0000;
        end else if (wr && paddr == `TCM_OFS_MODE) begin
            mode_q <= pwdata[15:0];
        end else if (wr && paddr == `TCM_OFS_CMP1) begin
            buf_q <= pwdata[15:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_PREADY_UP: assert property ($past(presetn) |-> pready)
        else $error("pready low after reset release");
    AST_MAPPED_OK: assert property (psel && penable && pready
        && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped address");
    AST_OCM1_GATE: assert property (
        $stable(mode_q) && mode_q[1:0] != 2'b00 |-> chan1_output_mode == 3'b000)
        else $error("ch1 output mode active while input");
    AST_OCM1_SET: assert property (
        $stable(mode_q) && mode_q[1:0] == 2'b00
        |-> chan1_output_mode == mode_q[6:4])
        else $error("ch1 output mode differs from field");
    AST_OCM2_GATE: assert property (
        $stable(mode_q) && mode_q[9:8] != 2'b00 |-> chan2_output_mode == 3'b000)
        else $error("ch2 output mode active while input");
    AST_FAST_GATE: assert property (
        $stable(mode_q) && mode_q[1:0] != 2'b00 |-> !fast_enable_q[0])
        else $error("ch1 fast enable while input");
    AST_TRIG_PWM: assert property (oc_trig_match_q[0]
        |-> mode_q[1:0] == 2'b00 && mode_q[6:5] == 2'b11)
        else $error("trigger match outside pwm output");
    AST_CAP2_IN: assert property (cap_event_q[1] |-> mode_q[9:8] != 2'b00)
        else $error("ch2 capture while output");
    AST_CAP1_PULSE: assert property (cap_event_q[0] |=> !cap_event_q[0])
        else $error("ch1 capture longer than one cycle");
    AST_BUF_LOAD: assert property (update_event && mode_q[3]
        && mode_q[1:0] == 2'b00 |=> cmp1_active_q == $past(buf_q))
        else $error("buffered compare not loaded on update");
    AST_NOBUF_WR: assert property (wr && paddr == `TCM_OFS_CMP1
        && !mode_q[3] |=> cmp1_active_q == buf_q)
        else $error("unbuffered compare write not immediate");
endmodule // tcm_chan_cfg_sva
bind tcm_chan_cfg tcm_chan_cfg_sva u_sva (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .update_event, .cap_event_q,
    .oc_trig_match_q, .chan1_output_mode, .chan2_output_mode, .fast_enable_q,
    .cmp1_active_q);
`default_nettype wire

/* dv/tcm_pin_model.sv */
// timer input pins and trigger sources facing tcm_chan_cfg
`timescale 1ns/100ps
`default_nettype none
module tcm_pin_model (
    input wire logic pclk,
    input wire logic [2:0] tsel,
    output logic ti1 = 1'b0,
    output logic ti2 = 1'b0,
    output logic [7:0] itrig = 8'h00
);
    // source 2 hits the selected trigger, 3 an unselected one
    task set(input int src, input logic v);
        @(posedge pclk);
        if (src == 0) ti1 <= v;
        else if (src == 1) ti2 <= v;
        else itrig[src == 2 ? tsel : tsel + 3'h1] <= v;
    endtask
    // short pulse, wide enough for the two-stage synchroniser
    task pulse(input int src);
        set(src, 1'b1);
        repeat (3) @(posedge pclk);
        set(src, 1'b0);
        repeat (5) @(posedge pclk);
    endtask
endmodule // tcm_pin_model
`default_nettype wire

/* dv/tb_tcm_chan_cfg.sv */
// self-checking bench for tcm_chan_cfg
`timescale 1ns/100ps
`default_nettype none
`include "tcm_defs.vh"
module tb_tcm_chan_cfg;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, update_event = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic err;
    logic [2:0] tsel = 3'h5;
    wire [31:0] prdata;
    wire pready, pslverr, ti1, ti2;
    wire [7:0] itrig;
    wire [1:0] cap, ocm, fast;
    wire [2:0] om1, om2;
    wire [15:0] a1, a2;
    int num_errors = 0, samples_checked = 0, e1 = 0, e2 = 0, e3 = 0;
    int n, m, k, k0;
    always #4 pclk = ~pclk;
    tcm_chan_cfg dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_input_one(ti1), .timer_input_two(ti2), .internal_trigger(itrig),
        .update_event(update_event), .cap_event_q(cap), .oc_trig_match_q(ocm),
        .chan1_output_mode(om1), .chan2_output_mode(om2), .fast_enable_q(fast),
        .cmp1_active_q(a1), .cmp2_active_q(a2));
    tcm_pin_model pins (.pclk(pclk), .tsel(tsel), .ti1(ti1), .ti2(ti2),
        .itrig(itrig));
    // event tallies; scenarios compare differences, never absolutes
    always @(posedge pclk) begin
        e1 <= e1 + cap[0];
        e2 <= e2 + cap[1];
        e3 <= e3 + ocm[0];
    end
    task chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // one apb transfer; waits on pready, only the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // cycles from a rising ti1 to the ch1 capture pulse
    task lat(output int c);
        pins.set(0, 1'b1);
        c = 0;
        while (cap[0] !== 1'b1) begin
            @(posedge pclk);
            c++;
        end
        pins.set(0, 1'b0);
        repeat (400) @(posedge pclk);
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [31:0] hit(int ch, int s, int d);
        return 32'(s == 2 ? d == 3 : s == 3 ? 0 : (s ^ ch) == d - 1);
    endfunction
    // watchdog well beyond the expected run
    initial begin
        repeat (30000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `TCM_OFS_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `TCM_OFS_MODE, 32'hFFFF_FFFF);
        apb(1'b0, `TCM_OFS_MODE, 32'h0000_0000);
        chk(rd, 32'h0000_FFFF);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        apb(1'b1, `TCM_OFS_TRIG, 32'(tsel));
        for (int d = 1; d < 4; d++) begin
            apb(1'b1, `TCM_OFS_CHEN, 32'h0000_0000);
            apb(1'b1, `TCM_OFS_MODE, {22'h0, d[1:0], 6'h00, d[1:0]});
            apb(1'b1, `TCM_OFS_CHEN, 32'h0000_0003);
            apb(1'b0, `TCM_OFS_STAT, 32'h0000_0000);
            chk(32'(rd[3:2]), 32'h0000_0003);
            for (int s = 0; s < 4; s++) begin
                n = e1;
                m = e2;
                pins.pulse(s);
                chk(32'(e1 - n), hit(0, s, d));
                chk(32'(e2 - m), hit(1, s, d));
            end
        end
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, `TCM_OFS_CHEN, 32'h0000_0000);
            apb(1'b1, `TCM_OFS_MODE, {20'h0, p[1:0], 6'h20, p[1:0], 2'b01});
            n = e1;
            m = e2;
            repeat (12) pins.pulse(0);
            chk(32'(e1 - n), 32'(12 / (p == 3 ? 6 : 1 << p)));
            chk(32'(e2 - m), 32'(12 / (p == 3 ? 6 : 1 << p)));
            chk(32'(fast), 32'h0000_0000);
        end
        // same trigger, slow then fast path; only the gap is fixed
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, `TCM_OFS_MODE, 32'(16'h0060 | (f << 2)));
            pins.set(2, 1'b1);
            k = 0;
            while (ocm[0] !== 1'b1) begin
                @(posedge pclk);
                k++;
            end
            pins.set(2, 1'b0);
            chk(32'(om1), 32'h0000_0006);
            if (f == 0) k0 = k;
        end
        chk(32'(k0 - k), 32'(`TCM_SLOW_DLY - `TCM_FAST_DLY));
        apb(1'b1, `TCM_OFS_MODE, 32'h0000_0004);
        n = e3;
        pins.pulse(2);
        chk(32'(e3 - n), 32'h0000_0000);
        chk(32'(fast), 32'h0000_0001);
        apb(1'b1, `TCM_OFS_CMP1, 32'h0000_00AA);
        @(posedge pclk);
        chk(32'(a1), 32'h0000_00AA);
        apb(1'b1, `TCM_OFS_MODE, 32'h0000_0008);
        apb(1'b1, `TCM_OFS_CMP1, 32'h0000_1234);
        @(posedge pclk);
        chk(32'(a1), 32'h0000_00AA);
        apb(1'b0, `TCM_OFS_CMP1, 32'h0000_0000);
        chk(rd, 32'h0000_1234);
        apb(1'b1, `TCM_OFS_CMP2, 32'h0000_0055);
        update_event <= 1'b1;
        @(posedge pclk);
        update_event <= 1'b0;
        @(posedge pclk);
        chk(32'(a1), 32'h0000_1234);
        chk(32'(a2), 32'h0000_0055);
        // ch2 output mode shows while output, frozen once an input
        apb(1'b1, `TCM_OFS_MODE, 32'h0000_5000);
        repeat (2) @(posedge pclk);
        chk(32'(om2), 32'h0000_0005);
        apb(1'b1, `TCM_OFS_MODE, 32'h0000_5100);
        repeat (2) @(posedge pclk);
        chk(32'(om2), 32'h0000_0000);
        apb(1'b1, `TCM_OFS_MODE, 32'h0000_0031);
        lat(k0);
        apb(1'b1, `TCM_OFS_CLKS, 32'h0000_0001);
        lat(k);
        chk(32'(k - k0 >= 60 && k - k0 <= 100), 32'h0000_0001);
        apb(1'b1, `TCM_OFS_MODE, 32'h0000_0001);
        lat(k);
        chk(32'(k <= 10), 32'h0000_0001);
        end_of_test;
    end
endmodule // tb_tcm_chan_cfg
`default_nettype wire
